// ### hdl/aif_pkg.sv
// shared constants, types and helpers for the audio filter chain
package aif_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_S1_COEF = 8'h04;
	localparam logic [7:0] ADDR_SEP_COEF = 8'h08;
	localparam logic [7:0] ADDR_TONE_AB = 8'h0C;
	localparam logic [7:0] ADDR_TONE_C = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_LADC = 0;
	localparam int CTRL_RADC = 1;
	localparam int CTRL_DAC = 2;
	localparam int CTRL_SEP_EN = 3;
	localparam int CTRL_TONE_EN = 4;
	localparam int CTRL_S1_EN = 5;
	localparam int CTRL_S1_TYPE = 6;
	localparam int CTRL_SEP_TYPE = 7;
	localparam int CTRL_BOOST_LO = 8;
	localparam int CTRL_MIC_LO = 10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0400;
	localparam logic [31:0] COEF_RESET = 32'h0000_0000;
	localparam logic [11:0] CTRL_MASK = 12'hFFF;
	localparam int COEF_NUM_LO = 0;
	localparam int COEF_FB_LO = 16;
	localparam int STAT_FIFO_LO = 4;
	localparam int FRAC_BITS = 13;
	localparam int SAT_W = 48;
	localparam int BOOST_SH_12 = 2;
	localparam int BOOST_SH_24 = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] MIC_DB_0 = 8'h00;
	localparam logic [7:0] MIC_DB_20 = 8'h14;
	localparam logic [7:0] MIC_DB_26 = 8'h1A;
	localparam logic [7:0] MIC_DB_32 = 8'h20;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		PATH_OFF = 2'b00,
		PATH_PLAY = 2'b01,
		PATH_REC = 2'b10
	} aif_path_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_HOLD = 1'b1
	} aif_state_t;

	typedef struct packed {
		logic signed [15:0] l;
		logic signed [15:0] r;
	} aif_pair_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic signed [15:0] sat16(input logic signed [SAT_W-1:0] v);
		if (v > 48'sh0000_0000_7FFF) begin
			sat16 = 16'sh7FFF;
		end else if (v < -48'sh0000_0000_8000) begin
			sat16 = -16'sh8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	function automatic logic [7:0] mic_gain_db(input logic [1:0] sel);
		case (sel)
			2'h0: mic_gain_db = MIC_DB_0;
			2'h1: mic_gain_db = MIC_DB_20;
			2'h2: mic_gain_db = MIC_DB_26;
			default: mic_gain_db = MIC_DB_32;
		endcase
	endfunction : mic_gain_db

endpackage : aif_pkg

// ### hdl/aif_fifo.sv
// sample fifo with valid/ready on both sides
module aif_fifo import aif_pkg::*; #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;
	logic [WIDTH-1:0] out_q, out_d;

	// ----------------------------------------
	// pointers and count
	// ----------------------------------------
	always_comb begin
		in_ready = (cnt_q != (AW+1)'(DEPTH));
		out_valid = (cnt_q != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end
		// read ahead from the next slot; forward a word landing there this cycle
		out_d = (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage holds no reset; only written words are ever read
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
		out_q <= out_d;
	end

	assign out_data = out_q;
	assign level = cnt_q;

endmodule : aif_fifo

// ### hdl/aif_iir_stage.sv
// one first-order recursive section y = (a*x + c*x1 - b*y1) / 2^13
module aif_iir_stage import aif_pkg::*; #(
	parameter int DW = 16,
	parameter int CW = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic clr,
	input wire logic step,
	// coefficients
	input wire logic signed [CW-1:0] ca,
	input wire logic signed [CW-1:0] cc,
	input wire logic signed [CW-1:0] cb,
	// samples
	input wire logic signed [DW-1:0] x,
	output logic signed [DW-1:0] y
);
	localparam int PW = DW + CW;

	logic signed [DW-1:0] x1_q, x1_d, y1_q, y1_d;
	logic signed [SAT_W-1:0] acc;

	// ----------------------------------------
	// difference equation and history
	// ----------------------------------------
	always_comb begin
		acc = SAT_W'(PW'(ca * x)) + SAT_W'(PW'(cc * x1_q)) - SAT_W'(PW'(cb * y1_q));
		y = sat16(acc >>> FRAC_BITS);
		x1_d = step ? x : x1_q;
		y1_d = step ? y : y1_q;
		// idle stages forget history so a re-enable starts clean
		if (clr) begin
			x1_d = '0;
			y1_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x1_q <= '0;
			y1_q <= '0;
		end else begin
			x1_q <= x1_d;
			y1_q <= y1_d;
		end
	end

endmodule : aif_iir_stage

// ### hdl/aif_filter_chain.sv
// programmable audio filter chain with axi4-lite registers
module aif_filter_chain import aif_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// samples from the converter path
	input wire logic smp_in_valid,
	output logic smp_in_ready,
	input wire aif_pair_t smp_in_data,
	// samples to level control
	output logic smp_out_valid,
	input wire logic smp_out_ready,
	output aif_pair_t smp_out_data,
	// path and mic preamp control
	output aif_path_t path_sel,
	output logic [1:0] mic_amp_gain_sel,
	output logic [7:0] mic_gain_db
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			apply_strb[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : apply_strb

	function automatic logic signed [15:0] sext14(input logic [13:0] v);
		sext14 = {{2{v[13]}}, v};
	endfunction : sext14

	// z^-1 term of a high/low-pass section
	function automatic logic signed [15:0] zero_coef(input logic [13:0] a, input logic lp);
		zero_coef = lp ? sext14(a) : -sext14(a);
	endfunction : zero_coef

	// ----------------------------------------
	// register bus state
	// ----------------------------------------
	logic [31:0] ctrl_q, ctrl_d, s1_q, s1_d, sep_q, sep_d, tab_q, tab_d, tc_q, tc_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
	logic rvalid_q, rvalid_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [LW-1:0] fifo_level;
	logic do_write, ar_take;

	// ----------------------------------------
	// datapath state
	// ----------------------------------------
	aif_state_t st_q, st_d;
	aif_pair_t out_q, out_d, fifo_word, chain_res;
	aif_path_t path;
	logic fifo_valid, pop, chain_off, mono;
	logic sep_en, tone_en, s1_en;
	logic signed [15:0] xin [2];
	logic signed [15:0] xcross [2];
	logic signed [15:0] sep_y [2];
	logic signed [15:0] tone_y [2];
	logic signed [15:0] s1_y [2];
	logic signed [15:0] after_sep [2];
	logic signed [15:0] after_tone [2];
	logic signed [15:0] after_s1 [2];
	logic signed [15:0] boosted [2];

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	always_comb begin
		s_axi_awready = !aw_have_q && !bvalid_q;
		s_axi_wready = !w_have_q && !bvalid_q;
		s_axi_arready = !rvalid_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		// write lands one cycle after both halves are held
		do_write = aw_have_q && w_have_q && !bvalid_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		s1_d = s1_q;
		sep_d = sep_q;
		tab_d = tab_q;
		tc_d = tc_q;
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case ({awaddr_q[7:2], 2'b00})
				ADDR_CTRL: ctrl_d = apply_strb(ctrl_q, wdata_q, wstrb_q) & 32'(CTRL_MASK);
				ADDR_S1_COEF: s1_d = apply_strb(s1_q, wdata_q, wstrb_q);
				ADDR_SEP_COEF: sep_d = apply_strb(sep_q, wdata_q, wstrb_q);
				ADDR_TONE_AB: tab_d = apply_strb(tab_q, wdata_q, wstrb_q);
				ADDR_TONE_C: tc_d = apply_strb(tc_q, wdata_q, wstrb_q);
				ADDR_STATUS: bresp_d = RESP_OKAY;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		ar_take = s_axi_arvalid && s_axi_arready;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (ar_take) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				ADDR_CTRL: rdata_d = ctrl_q;
				ADDR_S1_COEF: rdata_d = s1_q & 32'h3FFF_3FFF;
				ADDR_SEP_COEF: rdata_d = sep_q & 32'h3FFF_3FFF;
				ADDR_TONE_AB: rdata_d = tab_q & 32'h3FFF_FFFF;
				ADDR_TONE_C: rdata_d = tc_q & 32'h0000_FFFF;
				ADDR_STATUS: rdata_d = 32'({fifo_level, st_q, path});
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	// coefficients reset only with the bus reset, never on a path change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			s1_q <= COEF_RESET;
			sep_q <= COEF_RESET;
			tab_q <= COEF_RESET;
			tc_q <= COEF_RESET;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			s1_q <= s1_d;
			sep_q <= sep_d;
			tab_q <= tab_d;
			tc_q <= tc_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ----------------------------------------
	// path selection and mic gain
	// ----------------------------------------
	always_comb begin
		if (ctrl_q[CTRL_LADC] || ctrl_q[CTRL_RADC]) begin
			path = PATH_REC;
		end else if (ctrl_q[CTRL_DAC]) begin
			path = PATH_PLAY;
		end else begin
			path = PATH_OFF;
		end
		chain_off = (path == PATH_OFF);
		// one adc alone feeds the same signal to both channels
		mono = (path == PATH_REC) && (ctrl_q[CTRL_LADC] != ctrl_q[CTRL_RADC]);
		sep_en = ctrl_q[CTRL_SEP_EN];
		tone_en = ctrl_q[CTRL_TONE_EN];
		s1_en = ctrl_q[CTRL_S1_EN];
	end

	assign path_sel = path;
	assign mic_amp_gain_sel = ctrl_q[CTRL_MIC_LO +: 2];
	assign mic_gain_db = aif_pkg::mic_gain_db(ctrl_q[CTRL_MIC_LO +: 2]);

	// ----------------------------------------
	// input buffer
	// ----------------------------------------
	// powered-down chain flushes, so stale samples never leak into a path started from off
	aif_fifo #(
		.WIDTH($bits(aif_pair_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.flush(chain_off),
		.in_valid(smp_in_valid && !chain_off),
		.in_ready(smp_in_ready),
		.in_data(smp_in_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_word),
		.level(fifo_level)
	);

	// ----------------------------------------
	// filter sections, one set per channel
	// ----------------------------------------
	assign xin[0] = fifo_word.l;
	assign xin[1] = fifo_word.r;
	assign xcross[0] = fifo_word.r;
	assign xcross[1] = fifo_word.l;

	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		// separation section filters the opposite channel
		aif_iir_stage u_sep (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(!sep_en || chain_off),
			.step(pop),
			.ca(sext14(sep_q[COEF_NUM_LO +: 14])),
			.cc(zero_coef(sep_q[COEF_NUM_LO +: 14], ctrl_q[CTRL_SEP_TYPE])),
			.cb(sext14(sep_q[COEF_FB_LO +: 14])),
			.x(xcross[ch]),
			.y(sep_y[ch])
		);
		aif_iir_stage u_tone (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(!tone_en || chain_off),
			.step(pop),
			.ca(tab_q[COEF_NUM_LO +: 16]),
			.cc(tc_q[COEF_NUM_LO +: 16]),
			.cb(sext14(tab_q[COEF_FB_LO +: 14])),
			.x(after_sep[ch]),
			.y(tone_y[ch])
		);
		aif_iir_stage u_s1 (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(!s1_en || chain_off),
			.step(pop),
			.ca(sext14(s1_q[COEF_NUM_LO +: 14])),
			.cc(zero_coef(s1_q[COEF_NUM_LO +: 14], ctrl_q[CTRL_S1_TYPE])),
			.cb(sext14(s1_q[COEF_FB_LO +: 14])),
			.x(after_tone[ch]),
			.y(s1_y[ch])
		);

		always_comb begin
			// subtracting filtered crosstalk widens the image; muted section adds nothing
			if (mono) begin
				after_sep[ch] = xin[ch];
			end else if (!sep_en) begin
				after_sep[ch] = xin[ch];
			end else begin
				after_sep[ch] = sat16(SAT_W'(xin[ch]) - SAT_W'(sep_y[ch]));
			end
			after_tone[ch] = tone_en ? tone_y[ch] : after_sep[ch];
			after_s1[ch] = s1_en ? s1_y[ch] : after_tone[ch];
			case (ctrl_q[CTRL_BOOST_LO +: 2])
				2'h0: boosted[ch] = after_s1[ch];
				2'h1: boosted[ch] = sat16(SAT_W'(after_s1[ch]) <<< BOOST_SH_12);
				default: boosted[ch] = sat16(SAT_W'(after_s1[ch]) <<< BOOST_SH_24);
			endcase
		end
	end

	assign chain_res.l = boosted[0];
	assign chain_res.r = boosted[1];

	// ----------------------------------------
	// one sample pair per step, held until taken or the chain powers down
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		out_d = out_q;
		pop = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (fifo_valid && !chain_off) begin
					pop = 1'b1;
					out_d = chain_res;
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (smp_out_ready) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		if (chain_off) begin
			st_d = ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			out_q <= '0;
		end else begin
			st_q <= st_d;
			out_q <= out_d;
		end
	end

	assign smp_out_valid = (st_q == ST_HOLD);
	assign smp_out_data = out_q;

endmodule : aif_filter_chain

// ### testbench/aif_filter_chain_monitor.sv
// port-level checks for the audio filter chain
module aif_filter_chain_monitor import aif_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// samples and control
	input wire logic smp_out_valid,
	input wire logic smp_out_ready,
	input wire aif_pair_t smp_out_data,
	input wire aif_path_t path_sel,
	input wire logic [1:0] mic_amp_gain_sel,
	input wire logic [7:0] mic_gain_db
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_mic_gain_map: assert property (
		mic_gain_db == (mic_amp_gain_sel[1] ? (mic_amp_gain_sel[0] ? 8'h20 : 8'h1A)
		: (mic_amp_gain_sel[0] ? 8'h14 : 8'h00)))
		else $error("mic gain differs from selection");
	// a path change needs one edge to clear the output slot, hence two off cycles
	a_off_no_out: assert property (
		path_sel == PATH_OFF && $past(path_sel) == PATH_OFF |-> !smp_out_valid)
		else $error("sample output while powered down");
	a_out_hold: assert property (
		smp_out_valid && !smp_out_ready && path_sel != PATH_OFF
		|=> smp_out_valid && $stable(smp_out_data))
		else $error("sample output lost or changed while stalled");
	a_out_gap: assert property (
		smp_out_valid && smp_out_ready |=> !smp_out_valid)
		else $error("sample output faster than one pair per two cycles");
	a_wr_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_rd_unmapped: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : aif_filter_chain_monitor

bind aif_filter_chain aif_filter_chain_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready),
	.smp_out_data(smp_out_data), .path_sel(path_sel),
	.mic_amp_gain_sel(mic_amp_gain_sel), .mic_gain_db(mic_gain_db));

// ### testbench/aif_level_sink.sv
// sample sink standing in for the level-control stage
module aif_level_sink import aif_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// sample stream from the chain
	input wire logic smp_out_valid,
	output logic smp_out_ready,
	input wire aif_pair_t smp_out_data,
	// bench control and capture
	input wire logic stall,
	output int cnt_q,
	output aif_pair_t got_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// ready obeys the bench only, so the chain must cope with any stall pattern
	assign smp_out_ready = !stall;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 0;
			got_q <= '0;
		end else if (smp_out_valid && smp_out_ready) begin
			cnt_q <= cnt_q + 1;
			got_q <= smp_out_data;
		end
	end
endmodule : aif_level_sink

// ### testbench/aif_filter_chain_tb.sv
// self-checking bench for the audio filter chain
module aif_filter_chain_tb import aif_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// signals
	// ----------
	localparam int FIFO_DEPTH = 16;
	typedef struct {logic [11:0] c; logic [7:0] a; logic [31:0] d; int xl, xr, yl, yr;} aif_row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic smp_in_valid = 1'b0;
	logic stall = 1'b0;
	aif_pair_t smp_in_data = '0;
	logic awready, wready, bvalid, arready, rvalid, smp_in_ready, smp_out_valid, smp_out_ready;
	logic [1:0] bresp, rresp, mic_sel;
	logic [31:0] rdata;
	logic [7:0] mic_db;
	aif_pair_t smp_out_data, got_q;
	aif_path_t path_sel;
	int cnt_q;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] mic_tab [4] = '{8'h00, 8'h14, 8'h1A, 8'h20};
	aif_row_t rows [10] = '{'{12'h003, 8'h04, 0, 1000, 400, 1000, 400},
		'{12'h404, 8'h04, 0, 1000, 400, 1000, 400}, '{12'h801, 8'h04, 0, 1000, 400, 1000, 400},
		'{12'hD02, 8'h04, 0, 1000, -400, 4000, -1600},
		'{12'h207, 8'h04, 0, 1000, -400, 16000, -6400},
		'{12'h307, 8'h04, 0, 3000, -3000, 32767, -32768},
		'{12'h08B, 8'h08, 32'h1000, 1000, 400, 800, -100},
		'{12'h089, 8'h08, 32'h1000, 1000, 400, 1000, 400},
		'{12'h213, 8'h0C, 32'h1000, 3000, 400, 24000, 3200},
		'{12'h063, 8'h04, 32'h1000, 1000, 400, 500, 200}};

	aif_filter_chain #(.FIFO_DEPTH(FIFO_DEPTH)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.smp_in_valid(smp_in_valid), .smp_in_ready(smp_in_ready), .smp_in_data(smp_in_data),
		.smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready),
		.smp_out_data(smp_out_data), .path_sel(path_sel), .mic_amp_gain_sel(mic_sel),
		.mic_gain_db(mic_db));
	aif_level_sink sink (.aclk(aclk), .aresetn(aresetn), .smp_out_valid(smp_out_valid),
		.smp_out_ready(smp_out_ready), .smp_out_data(smp_out_data), .stall(stall),
		.cnt_q(cnt_q), .got_q(got_q));

	initial begin
		forever #12.5 aclk = ~aclk;
	end
	// ----------
	// tasks
	// ----------
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset
	// the response is taken one edge late on purpose, so it has to stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic send(input aif_pair_t p);
		@(posedge aclk);
		smp_in_data <= p;
		smp_in_valid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (smp_in_ready) break;
		end
		smp_in_valid <= 1'b0;
	endtask : send
	task automatic xfer(input aif_pair_t p, input aif_pair_t e);
		int c;
		c = cnt_q;
		send(p);
		for (int n = 0; n < 50 && cnt_q == c; n++) @(posedge aclk);
		chk("sample", got_q, e);
	endtask : xfer

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	// ----------
	// main sequence
	// ----------
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int n, c;
		aif_row_t w;
		do_reset();
		rd(ADDR_CTRL, d, r);
		chk("ctrl_reset", d, 32'h0000_0400);
		rd(ADDR_S1_COEF, d, r);
		chk("coef_reset", d, 32'h0000_0000);
		chk("path_reset", path_sel, 2'b00);
		chk("mic_db_reset", mic_db, 8'h14);
		foreach (rows[i]) begin
			w = rows[i];
			wr(ADDR_CTRL, 32'h0, r);
			wr(w.a, w.d, r);
			wr(ADDR_CTRL, {20'h0, w.c}, r);
			chk("ctrl_resp", r, RESP_OKAY);
			xfer({16'(w.xl), 16'(w.xr)}, {16'(w.yl), 16'(w.yr)});
			chk("path", path_sel, w.c[1:0] != 2'b00 ? 2'b10 : {1'b0, w.c[2]});
			chk("mic_sel", mic_sel, w.c[11:10]);
			chk("mic_db", mic_db, mic_tab[w.c[11:10]]);
		end
		// feedback of -0.5 shows up only in the second sample
		wr(ADDR_CTRL, 32'h0, r);
		wr(ADDR_S1_COEF, 32'h3000_1000, r);
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_CTRL, 32'h0, r);
			wr(ADDR_CTRL, 32'h023 | (k << 6), r);
			xfer({16'sd1000, 16'sd400}, {16'sd500, 16'sd200});
			xfer({16'sd1000, 16'sd400}, k ? {16'sd1250, 16'sd500} : {16'sd250, 16'sd100});
		end
		// high-pass separation: second sample sees no crosstalk
		wr(ADDR_CTRL, 32'h0, r);
		wr(ADDR_CTRL, 32'h00B, r);
		xfer({16'sd1000, 16'sd400}, {16'sd800, -16'sd100});
		xfer({16'sd1000, 16'sd400}, {16'sd1000, 16'sd400});
		wr(ADDR_CTRL, 32'h064, r);
		rd(ADDR_CTRL, d, r);
		chk("ctrl_kept", d, 32'h0000_0064);
		rd(ADDR_S1_COEF, d, r);
		chk("coef_kept", d, 32'h3000_1000);
		chk("path_play", path_sel, 2'b01);
		wstrb <= 4'h1;
		wr(ADDR_CTRL, 32'h0000_0F03, r);
		wstrb <= 4'hF;
		rd(ADDR_CTRL, d, r);
		chk("ctrl_strb", d, 32'h0000_0003);
		wr(ADDR_CTRL, 32'hFFFF_F000, r);
		rd(ADDR_CTRL, d, r);
		chk("ctrl_upper", d, 32'h0);
		c = cnt_q;
		send({16'sd1, 16'sd1});
		repeat (10) @(posedge aclk);
		chk("off_drop", cnt_q, c);
		wr(ADDR_STATUS, 32'hFFFF_FFFF, r);
		chk("status_wr", r, RESP_OKAY);
		wr(8'h18, 32'h1, r);
		chk("bad_wr", r, RESP_SLVERR);
		rd(8'h18, d, r);
		chk("bad_rd", d, 32'h0);
		chk("bad_rresp", r, RESP_SLVERR);
		// fifo plus the held output slot fill before input is refused
		wr(ADDR_CTRL, 32'h003, r);
		stall <= 1'b1;
		c = cnt_q;
		@(posedge aclk);
		smp_in_valid <= 1'b1;
		smp_in_data <= '0;
		n = 0;
		for (int k = 0; k < 100; k++) begin
			@(posedge aclk);
			if (!smp_in_ready) break;
			n++;
			smp_in_data <= {16'(n), 16'(n)};
		end
		smp_in_valid <= 1'b0;
		chk("fifo_fill", n, FIFO_DEPTH + 1);
		rd(ADDR_STATUS, d, r);
		chk("status_full", d, 32'h0000_0086);
		for (int k = 0; k < 400 && cnt_q != c + n; k++) begin
			stall <= k[0];
			@(posedge aclk);
		end
		stall <= 1'b0;
		chk("fifo_drain", cnt_q - c, n);
		chk("fifo_last", got_q, {16'(n - 1), 16'(n - 1)});
		wr(ADDR_CTRL, 32'h004, r);
		do_reset();
		rd(ADDR_CTRL, d, r);
		chk("ctrl_rereset", d, 32'h0000_0400);
		stop_test();
	end
endmodule : aif_filter_chain_tb
